/* rtl/tws_pkg.sv */
package tws_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_OWN_ADDR = 8'h00;
    localparam logic [7:0] OFF_CTRL     = 8'h04;
    localparam logic [7:0] OFF_STATUS   = 8'h08;
    localparam logic [7:0] OFF_DATA     = 8'h0c;
    localparam logic [7:0] OFF_IRQ_ST   = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

    // Control register fields
    localparam int CTL_FLAG   = 7;
    localparam int CTL_ACK_EN = 6;
    localparam int CTL_START  = 5;
    localparam int CTL_STOP   = 4;
    localparam int CTL_WCOL   = 3;
    localparam int CTL_EN     = 2;
    localparam int CTL_IE     = 0;

    // Own address register fields
    localparam int OWN_GC_BIT = 0;

    // Interrupt status and mask fields
    localparam int IRQ_FLAG = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_WCOL = 2;
    localparam int IRQ_W    = 3;

    // Status codes
    localparam logic [7:0] ST_SLA_R_ACK = 8'ha8;
    localparam logic [7:0] ST_ARB_SLA_R = 8'hb0;
    localparam logic [7:0] ST_DATA_ACK  = 8'hb8;
    localparam logic [7:0] ST_DATA_NACK = 8'hc0;
    localparam logic [7:0] ST_LAST_ACK  = 8'hc8;
    localparam logic [7:0] ST_NO_INFO   = 8'hf8;

    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;

    // Reset values
    localparam logic [7:0] RST_OWN_ADDR = 8'h00;
    localparam logic [7:0] RST_DATA     = 8'hff;
    localparam logic [1:0] RST_PRESC    = 2'h0;
    localparam logic [2:0] RST_IRQ      = 3'h0;

    typedef enum logic [2:0] {
        S_IDLE     = 3'b000,
        S_ADDR     = 3'b001,
        S_ADDR_ACK = 3'b010,
        S_HOLD     = 3'b011,
        S_TX       = 3'b100,
        S_TX_ACK   = 3'b101,
        S_END_HOLD = 3'b110,
        S_SKIP     = 3'b111
    } tws_state_e;

endpackage

/* rtl/tws_ifs.sv */
`timescale 1ns/1ps
interface tws_reg_if;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slv (output wr, output addr, output wdata, input rdata);
    modport core (input wr, input addr, input wdata, output rdata);
endinterface

interface tws_line_if;
    logic scl_rise;
    logic scl_fall;
    logic sda;
    logic start_det;
    logic stop_det;
    modport src (output scl_rise, output scl_fall, output sda,
                 output start_det, output stop_det);
    modport dst (input scl_rise, input scl_fall, input sda,
                 input start_det, input stop_det);
endinterface

/* rtl/tws_ahb_slv.sv */
`timescale 1ns/1ps
module tws_ahb_slv (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Register side
    tws_reg_if.slv           regs
);
    logic       wr_pend_r;
    logic       rd_pend_r;
    logic [7:0] addr_r;
    logic       addr_phase;

    assign addr_phase = hsel & htrans[1] & hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end else begin
            wr_pend_r <= addr_phase & hwrite & (hsize == 3'h2);
            rd_pend_r <= addr_phase & ~hwrite;
            if (addr_phase) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    // Reads take one wait state so that hrdata comes from a flip-flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            hrdata <= {24'h00_0000, regs.rdata};
        end
    end

    assign hreadyout   = ~rd_pend_r;
    assign hresp       = 1'b0;
    assign regs.wr     = wr_pend_r;
    assign regs.addr   = addr_r;
    assign regs.wdata  = hwdata[7:0];

endmodule // tws_ahb_slv

/* rtl/tws_bus_mon.sv */
`timescale 1ns/1ps
module tws_bus_mon (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Line pins
    input  wire logic scl_i,
    input  wire logic sda_i,
    // Line events
    tws_line_if.src   line
);
    logic [2:0] scl_q_r;
    logic [2:0] sda_q_r;

    // Stage 0 feeds only stage 1; edges look at stages 1 and 2
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_q_r <= 3'h7;
            sda_q_r <= 3'h7;
        end else begin
            scl_q_r <= {scl_q_r[1:0], scl_i};
            sda_q_r <= {sda_q_r[1:0], sda_i};
        end
    end

    assign line.scl_rise  = scl_q_r[1] & ~scl_q_r[2];
    assign line.scl_fall  = ~scl_q_r[1] & scl_q_r[2];
    assign line.sda       = sda_q_r[1];
    assign line.start_det = scl_q_r[1] & scl_q_r[2] &
                            ~sda_q_r[1] & sda_q_r[2];
    assign line.stop_det  = scl_q_r[1] & scl_q_r[2] &
                            sda_q_r[1] & ~sda_q_r[2];

endmodule // tws_bus_mon

/* rtl/tws_slave_tx.sv */
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module tws_slave_tx (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Two-wire bus pins, open drain
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Chip-level signals
    input  wire logic        arb_lost_addr,
    input  wire logic        deep_sleep,
    output logic             wake_req,
    output logic             rx_select,
    output logic             start_issue,
    output logic             irq
);
    tws_reg_if  regs ();
    tws_line_if line ();

    tws_pkg::tws_state_e state_r;

    logic [7:0] own_addr_r;
    logic [7:0] data_r;
    logic [7:0] code_r;
    logic [1:0] presc_r;
    logic       flag_r;
    logic       ack_en_r;
    logic       start_req_r;
    logic       stop_req_r;
    logic       wcol_r;
    logic       en_r;
    logic       ie_r;
    logic [2:0] irq_st_r;
    logic [2:0] irq_mask_r;
    logic [7:0] shift_r;
    logic [2:0] bit_cnt_r;
    logic       got_r;
    logic       master_ack_r;
    logic       last_r;
    logic       rx_r;
    logic       sda_low_r;
    logic       setup_r;
    logic       busy_r;
    logic       start_pend_r;
    logic       rx_select_r;
    logic       start_issue_r;

    logic       addressed;
    logic       flag_set;
    logic       flag_clr;
    logic       wr_ctrl;
    logic       wr_data;
    logic       wcol_set;
    logic       own_hit;
    logic       gc_hit;
    logic       recog;
    logic [2:0] irq_ev;
    logic [7:0] ctrl_rd;

    function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
        sel = (a == off);
    endfunction

    tws_ahb_slv u_ahb (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .regs      (regs.slv)
    );

    tws_bus_mon u_mon (
        .hclk    (hclk),
        .hresetn (hresetn),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .line    (line.src)
    );

    assign wr_ctrl  = regs.wr & sel(regs.addr, tws_pkg::OFF_CTRL);
    assign wr_data  = regs.wr & sel(regs.addr, tws_pkg::OFF_DATA);
    assign flag_clr = wr_ctrl & regs.wdata[tws_pkg::CTL_FLAG] & flag_r;
    assign addressed = (state_r == tws_pkg::S_HOLD) ||
                       (state_r == tws_pkg::S_TX) ||
                       (state_r == tws_pkg::S_TX_ACK) ||
                       (state_r == tws_pkg::S_END_HOLD);
    assign wcol_set = wr_data & ~flag_r & addressed;

    assign own_hit = (shift_r[7:1] == own_addr_r[7:1]);
    assign gc_hit  = own_addr_r[tws_pkg::OWN_GC_BIT] &
                     (shift_r[7:1] == tws_pkg::GEN_CALL_ADDR);
    // Enable and ack enable are read live so recognition resumes at once
    assign recog   = en_r & ack_en_r & (own_hit | gc_hit);

    // Flag set on the SCL fall that closes an acked read address or data ack
    assign flag_set = line.scl_fall & ~line.start_det & (
        ((state_r == tws_pkg::S_ADDR_ACK) & ~rx_r) ||
        ((state_r == tws_pkg::S_TX_ACK) & got_r));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            own_addr_r <= tws_pkg::RST_OWN_ADDR;
            presc_r    <= tws_pkg::RST_PRESC;
            irq_mask_r <= tws_pkg::RST_IRQ;
        end else if (regs.wr) begin
            if (sel(regs.addr, tws_pkg::OFF_OWN_ADDR)) begin
                own_addr_r <= regs.wdata;
            end
            if (sel(regs.addr, tws_pkg::OFF_STATUS)) begin
                presc_r <= regs.wdata[1:0];
            end
            if (sel(regs.addr, tws_pkg::OFF_IRQ_MASK)) begin
                irq_mask_r <= regs.wdata[2:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_en_r    <= 1'b0;
            start_req_r <= 1'b0;
            stop_req_r  <= 1'b0;
            en_r        <= 1'b0;
            ie_r        <= 1'b0;
        end else if (wr_ctrl) begin
            ack_en_r    <= regs.wdata[tws_pkg::CTL_ACK_EN];
            start_req_r <= regs.wdata[tws_pkg::CTL_START];
            stop_req_r  <= regs.wdata[tws_pkg::CTL_STOP];
            en_r        <= regs.wdata[tws_pkg::CTL_EN];
            ie_r        <= regs.wdata[tws_pkg::CTL_IE];
        end
    end

    // Only software writes the data register; the shifter is separate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_r <= tws_pkg::RST_DATA;
        end else if (wr_data & ~wcol_set) begin
            data_r <= regs.wdata;
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r <= 1'b0;
        end else if (flag_set) begin
            flag_r <= 1'b1;
        end else if (flag_clr) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wcol_r <= 1'b0;
        end else if (wcol_set) begin
            wcol_r <= 1'b1;
        end else if (wr_data) begin
            wcol_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            code_r <= tws_pkg::ST_NO_INFO;
        end else if (flag_set) begin
            if (state_r == tws_pkg::S_ADDR_ACK) begin
                code_r <= arb_lost_addr ? tws_pkg::ST_ARB_SLA_R
                                        : tws_pkg::ST_SLA_R_ACK;
            end else if (!master_ack_r) begin
                code_r <= tws_pkg::ST_DATA_NACK;
            end else if (last_r) begin
                code_r <= tws_pkg::ST_LAST_ACK;
            end else begin
                code_r <= tws_pkg::ST_DATA_ACK;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r      <= tws_pkg::S_IDLE;
            shift_r      <= 8'h00;
            bit_cnt_r    <= 3'h0;
            got_r        <= 1'b0;
            master_ack_r <= 1'b0;
            last_r       <= 1'b0;
            rx_r         <= 1'b0;
            sda_low_r    <= 1'b0;
            rx_select_r  <= 1'b0;
        end else begin
            rx_select_r <= 1'b0;
            if (!en_r || line.stop_det) begin
                state_r   <= tws_pkg::S_IDLE;
                sda_low_r <= 1'b0;
            end else if (line.start_det) begin
                state_r   <= tws_pkg::S_ADDR;
                bit_cnt_r <= 3'h0;
                got_r     <= 1'b0;
                sda_low_r <= 1'b0;
            end else begin
                case (state_r)
                    tws_pkg::S_IDLE, tws_pkg::S_SKIP: begin
                        sda_low_r <= 1'b0;
                    end
                    tws_pkg::S_ADDR: begin
                        if (line.scl_rise && !got_r) begin
                            shift_r   <= {shift_r[6:0], line.sda};
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            got_r     <= (bit_cnt_r == 3'h7);
                        end else if (line.scl_fall && got_r) begin
                            got_r <= 1'b0;
                            if (recog) begin
                                sda_low_r   <= 1'b1;
                                rx_r        <= ~shift_r[0];
                                rx_select_r <= ~shift_r[0];
                                state_r     <= tws_pkg::S_ADDR_ACK;
                            end else begin
                                state_r <= tws_pkg::S_SKIP;
                            end
                        end
                    end
                    tws_pkg::S_ADDR_ACK: begin
                        if (line.scl_fall) begin
                            sda_low_r <= 1'b0;
                            state_r   <= rx_r ? tws_pkg::S_SKIP
                                              : tws_pkg::S_HOLD;
                        end
                    end
                    tws_pkg::S_HOLD: begin
                        if (flag_clr && !flag_set) begin
                            shift_r   <= data_r;
                            last_r    <= ~regs.wdata[tws_pkg::CTL_ACK_EN];
                            sda_low_r <= ~data_r[7];
                            bit_cnt_r <= 3'h0;
                            state_r   <= tws_pkg::S_TX;
                        end
                    end
                    tws_pkg::S_TX: begin
                        if (line.scl_fall) begin
                            if (bit_cnt_r == 3'h7) begin
                                sda_low_r <= 1'b0;
                                got_r     <= 1'b0;
                                state_r   <= tws_pkg::S_TX_ACK;
                            end else begin
                                shift_r   <= {shift_r[6:0], 1'b0};
                                sda_low_r <= ~shift_r[6];
                                bit_cnt_r <= bit_cnt_r + 3'h1;
                            end
                        end
                    end
                    tws_pkg::S_TX_ACK: begin
                        if (line.scl_rise) begin
                            master_ack_r <= ~line.sda;
                            got_r        <= 1'b1;
                        end else if (line.scl_fall && got_r) begin
                            got_r   <= 1'b0;
                            state_r <= (master_ack_r && !last_r)
                                       ? tws_pkg::S_HOLD
                                       : tws_pkg::S_END_HOLD;
                        end
                    end
                    tws_pkg::S_END_HOLD: begin
                        // SDA stays released, SCL is held until the flag clears: a master reading on gets ones
                        if (flag_clr && !flag_set) begin
                            state_r <= tws_pkg::S_IDLE;
                        end
                    end
                    default: begin
                        state_r <= tws_pkg::S_IDLE;
                    end
                endcase
            end
        end
    end

    // One extra cycle of hold gives SDA setup before SCL is let go
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            setup_r <= 1'b0;
        end else begin
            setup_r <= flag_clr & (state_r == tws_pkg::S_HOLD);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_r <= 1'b0;
        end else if (line.start_det) begin
            busy_r <= 1'b1;
        end else if (line.stop_det) begin
            busy_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_pend_r  <= 1'b0;
            start_issue_r <= 1'b0;
        end else begin
            start_issue_r <= start_pend_r & ~busy_r;
            if (flag_clr && state_r == tws_pkg::S_END_HOLD) begin
                start_pend_r <= regs.wdata[tws_pkg::CTL_START];
            end else if (start_pend_r && !busy_r) begin
                start_pend_r <= 1'b0;
            end
        end
    end

    localparam int IRQ_FLAG_IDX = tws_pkg::IRQ_FLAG;
    assign irq_ev[IRQ_FLAG_IDX] = flag_set & ie_r;
    assign irq_ev[tws_pkg::IRQ_STOP] = line.stop_det & addressed;
    assign irq_ev[tws_pkg::IRQ_WCOL] = wcol_set;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_r <= tws_pkg::RST_IRQ;
        end else begin
            irq_st_r <= irq_ev | (irq_st_r & ~(
                {3{regs.wr & sel(regs.addr, tws_pkg::OFF_IRQ_ST)}}
                & regs.wdata[2:0]));
        end
    end

    assign irq = |(irq_st_r & irq_mask_r);

    // Status shows no-info while the flag is clear; prescaler sits in [1:0]
    assign ctrl_rd = {flag_r, ack_en_r, start_req_r, stop_req_r,
                      wcol_r, en_r, 1'b0, ie_r};

    always_comb begin
        regs.rdata = 8'h00;
        case (regs.addr)
            tws_pkg::OFF_OWN_ADDR: regs.rdata = own_addr_r;
            tws_pkg::OFF_CTRL:     regs.rdata = ctrl_rd;
            tws_pkg::OFF_STATUS: begin
                regs.rdata = {(flag_r ? code_r[7:3]
                                      : tws_pkg::ST_NO_INFO[7:3]),
                              1'b0, presc_r};
            end
            tws_pkg::OFF_DATA:     regs.rdata = data_r;
            tws_pkg::OFF_IRQ_ST:   regs.rdata = {5'h00, irq_st_r};
            tws_pkg::OFF_IRQ_MASK: regs.rdata = {5'h00, irq_mask_r};
            default:               regs.rdata = 8'h00;
        endcase
    end

    // Clock runs on in deep sleep here; a read-address match asks the chip to wake
    assign wake_req    = deep_sleep & flag_r & addressed;
    assign scl_o       = 1'b0;
    assign scl_oe      = (flag_r & addressed) | setup_r;
    assign sda_o       = 1'b0;
    assign sda_oe      = sda_low_r;
    assign rx_select   = rx_select_r;
    assign start_issue = start_issue_r;

endmodule // tws_slave_tx

/* verif/tws_slave_tx_monitor.sv */
`timescale 1ns/1ps
module tws_slave_tx_monitor (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Observed ports
    input wire logic hresp,
    input wire logic scl_i,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic deep_sleep,
    input wire logic wake_req,
    input wire logic rx_select,
    input wire logic start_issue
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    property p_wake_hold; wake_req |-> !scl_i; endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("wake without scl hold");
    property p_wake_sleep; !deep_sleep |-> !wake_req; endproperty
    a_wake_sleep: assert property (p_wake_sleep)
        else $error("wake while awake");
    property p_rx_pulse; rx_select |=> !rx_select; endproperty
    a_rx_pulse: assert property (p_rx_pulse)
        else $error("rx_select too long");
    property p_start_pulse; start_issue |=> !start_issue; endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start_issue too long");
    property p_start_free; start_issue |-> !scl_oe && !sda_oe; endproperty
    a_start_free: assert property (p_start_free)
        else $error("start on held bus");
    // Data may only move while SCL is low, else it forms START or STOP
    property p_sda_low; $changed(sda_oe) |-> !scl_i; endproperty
    a_sda_low: assert property (p_sda_low)
        else $error("sda moved with scl high");
    property p_stretch; $rose(scl_oe) |-> !$past(scl_i); endproperty
    a_stretch: assert property (p_stretch)
        else $error("stretch began with scl high");
endmodule // tws_slave_tx_monitor

bind tws_slave_tx tws_slave_tx_monitor u_chk (.hclk, .hresetn, .hresp,
    .scl_i, .scl_oe, .sda_oe, .deep_sleep, .wake_req, .rx_select,
    .start_issue);

/* verif/tws_master.sv */
`timescale 1ns/1ps
module tws_master (
    // Bus lines
    input  wire logic scl,
    input  wire logic sda,
    // Open-drain pulls
    output logic      scl_low = 1'b0,
    output logic      sda_low = 1'b0
);
    // Low phase 40 ns, high 24 ns; waits while the slave stretches
    task automatic bit_io(input logic o, output logic i);
        sda_low = !o;
        #32;
        scl_low = 1'b0;
        wait (scl === 1'b1);
        #12;
        i = sda;
        #12;
        scl_low = 1'b1;
        #8;
    endtask
    task automatic start();
        sda_low = 1'b1;
        #32;
        scl_low = 1'b1;
        #8;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        #32;
        scl_low = 1'b0;
        wait (scl === 1'b1);
        #32;
        sda_low = 1'b0;
        #32;
    endtask
    // Extra low time after the ninth clock lets the flag settle
    task automatic xfer(input logic [7:0] o, input logic ao,
                        output logic [7:0] i, output logic ai);
        for (int k = 7; k >= 0; k--)
            bit_io(o[k], i[k]);
        bit_io(ao, ai);
        #32;
    endtask
endmodule // tws_master

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rdat;
    logic [1:0]  htrans = '0;
    logic        arb = 1'b0, dsl = 1'b0, rdy, a, got_rx = 0, got_st = 0;
    logic        hreadyout, hresp, scl_oe, sda_oe, wake_req, rx_select;
    logic        start_issue, irq, m_scl, m_sda;
    logic [7:0]  res_v, q_e, b, d, exp_q[$];
    logic [31:0] tab[5] = '{32'ha505a501, 32'ha545a701, 32'ha545a400,
                            32'ha5450000, 32'ha4450001};
    event        res_ev;
    int          failures = 0, tests_run = 0, seed = 43;
    wire logic   scl = !(scl_oe || m_scl);
    wire logic   sda = !(sda_oe || m_sda);

    always #2.5 hclk = !hclk;
    always @(negedge hclk) begin
        rdy = hreadyout;
        rdat = hrdata;
    end
    // Pulses are caught here so a later compare cannot miss them
    always @(posedge hclk) begin
        if (rx_select) got_rx <= 1'b1;
        if (start_issue) got_st <= 1'b1;
    end

    tws_slave_tx DUT (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda),
        .sda_o(), .sda_oe, .arb_lost_addr(arb), .deep_sleep(dsl),
        .wake_req, .rx_select, .start_issue, .irq);
    tws_master M (.scl, .sda, .scl_low(m_scl), .sda_low(m_sda));

    task automatic chk(input logic [7:0] act, input logic [7:0] e);
        #1;
        exp_q.push_back(e);
        res_v = act;
        -> res_ev;
    endtask
    always @(res_ev) begin
        q_e = exp_q.pop_front();
        tests_run++;
        if (res_v !== q_e) begin
            failures++;
            $display("[ERR] %0t exp %h got %h", $time, q_e, res_v);
        end
    end
    task automatic bus(input logic w, input logic [7:0] ad, wd);
        @(posedge hclk);
        haddr <= {24'h0, ad};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (rdy !== 1'b1);
        @(negedge hclk);
    endtask
    task automatic wr(input logic [7:0] ad, wd);
        bus(1'b1, ad, wd);
    endtask
    task automatic rd(input logic [7:0] ad, e);
        bus(1'b0, ad, 8'h00);
        chk(rdat[7:0], e);
    endtask
    task automatic own_slave_addr(input logic [7:0] ad, input logic e);
        M.start();
        M.xfer(ad, 1'b1, b, a);
        chk({7'h0, a}, {7'h0, e});
    endtask
    task automatic rdb(input logic ack, input logic [7:0] e);
        M.xfer(8'hff, ack, b, a);
        chk(b, e);
    endtask
    task automatic stop_test();
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rd(tws_pkg::OFF_STATUS, tws_pkg::ST_NO_INFO);
        rd(tws_pkg::OFF_DATA, tws_pkg::RST_DATA);
        rd(tws_pkg::OFF_OWN_ADDR, tws_pkg::RST_OWN_ADDR);
        rd(8'h40, 8'h00);
        wr(tws_pkg::OFF_OWN_ADDR, 8'ha5);
        wr(tws_pkg::OFF_IRQ_MASK, 8'h01);
        wr(tws_pkg::OFF_CTRL, 8'h45);
        own_slave_addr(8'ha5, 1'b0);
        rd(tws_pkg::OFF_STATUS, tws_pkg::ST_SLA_R_ACK);
        chk({7'h0, scl_oe}, 8'h01);
        d = 8'($random(seed));
        wr(tws_pkg::OFF_DATA, d);
        wr(tws_pkg::OFF_CTRL, 8'hc5);
        // Data write while shifting must be dropped and flag a collision
        wr(tws_pkg::OFF_DATA, 8'h00);
        rd(tws_pkg::OFF_CTRL, 8'h4d);
        rdb(1'b0, d);
        rd(tws_pkg::OFF_STATUS, tws_pkg::ST_DATA_ACK);
        d = 8'($random(seed));
        wr(tws_pkg::OFF_DATA, d);
        wr(tws_pkg::OFF_CTRL, 8'h85);
        rdb(1'b0, d);
        rd(tws_pkg::OFF_STATUS, tws_pkg::ST_LAST_ACK);
        wr(tws_pkg::OFF_CTRL, 8'hc5);
        rdb(1'b1, 8'hff);
        M.stop();
        @(posedge hclk);
        arb <= 1'b1;
        own_slave_addr(8'ha5, 1'b0);
        rd(tws_pkg::OFF_STATUS, tws_pkg::ST_ARB_SLA_R);
        d = 8'($random(seed));
        wr(tws_pkg::OFF_DATA, d);
        wr(tws_pkg::OFF_CTRL, 8'he5);
        rdb(1'b1, d);
        rd(tws_pkg::OFF_STATUS, tws_pkg::ST_DATA_NACK);
        wr(tws_pkg::OFF_CTRL, 8'he5);
        M.stop();
        chk({7'h0, got_st}, 8'h01);
        @(posedge hclk);
        arb <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            wr(tws_pkg::OFF_OWN_ADDR, tab[i][31:24]);
            wr(tws_pkg::OFF_CTRL, tab[i][23:16]);
            own_slave_addr(tab[i][15:8], tab[i][0]);
            M.stop();
        end
        chk({7'h0, got_rx}, 8'h01);
        @(posedge hclk);
        dsl <= 1'b1;
        own_slave_addr(8'ha5, 1'b0);
        chk({7'h0, wake_req}, 8'h01);
        wr(tws_pkg::OFF_CTRL, 8'h85);
        @(posedge hclk);
        dsl <= 1'b0;
        M.xfer(8'hff, 1'b1, b, a);
        rd(tws_pkg::OFF_STATUS, tws_pkg::ST_DATA_NACK);
        wr(tws_pkg::OFF_CTRL, 8'hc5);
        M.stop();
        wr(tws_pkg::OFF_IRQ_MASK, 8'h00);
        chk({7'h0, irq}, 8'h00);
        wr(tws_pkg::OFF_IRQ_MASK, 8'h01);
        chk({7'h0, irq}, 8'h01);
        wr(tws_pkg::OFF_IRQ_ST, 8'h07);
        chk({7'h0, irq}, 8'h00);
        stop_test();
    end
    initial begin
        #100000;
        failures++;
        stop_test();
    end
endmodule // tb
